// ==== iopeb_pkg.sv ====
// iopeb_pkg: register offsets, field positions, reset values and timing counts
// for the i/o ports and external memory bus block; assumes a 50 MHz mclk.
package iopeb_pkg;
   // ==========================================
   // register file offsets
   localparam logic [7:0] OFF_PORT_ZERO_DATA       = 8'h00;
   localparam logic [7:0] OFF_PORT_TWO_DATA        = 8'h02;
   localparam logic [7:0] OFF_PORT_THREE_DATA      = 8'h03;
   localparam logic [7:0] OFF_PORT_TWO_CONFIG      = 8'hf6;
   localparam logic [7:0] OFF_PORT_THREE_CONFIG    = 8'hf7;
   localparam logic [7:0] OFF_PORT_ZERO_ONE_CONFIG = 8'hf8;
   // ==========================================
   // port_zero_one_config fields
   localparam int P01_LO_ADDR_BIT  = 0;   // 1: low nibble carries A11..A8
   localparam int P01_HI_ADDR_BIT  = 1;   // 1: high nibble carries A15..A12
   localparam int P01_LO_OUT_BIT   = 2;   // i/o direction, 1 = output
   localparam int P01_HI_OUT_BIT   = 3;
   localparam int P01_FLOAT_BIT    = 4;   // float bus, request other master
   localparam int P01_EXT_TIME_BIT = 5;   // extended bus timing
   localparam logic [7:0] P01_RESET = 8'h23;
   // ==========================================
   // port_three_config fields
   localparam int P3M_P2_OPEN_DRAIN_BIT = 0;
   localparam int P3M_HS2_EN_BIT        = 1;
   localparam int P3M_HS0_EN_BIT        = 2;
   localparam int P3M_DM_EN_BIT         = 3;
   localparam logic [7:0] P3M_RESET = 8'h00;
   // port_two_config: bit set = input
   localparam logic [7:0] P2M_RESET = 8'hff;
   localparam logic [7:0] DATA_RESET = 8'h00;
   // ==========================================
   // reset filter and bus timing
   localparam int FILTER_PERIODS  = 4;    // low shorter than this is ignored
   localparam int LATCH_PERIOD    = 5;    // internal reset latched on this clock
   localparam int HOLD_PERIODS    = 18;   // least length of internal reset
   localparam logic [15:0] START_ADDR = 16'h000c;
   localparam int NORM_PHASE      = 1;    // cycles per bus phase, normal
   localparam int EXT_PHASE       = 2;    // cycles per bus phase, extended
   typedef enum logic [2:0] {IOPEB_IDLE, IOPEB_ADDR, IOPEB_GAP, IOPEB_DATA,
                             IOPEB_END} iopeb_state_t;
endpackage

// ==== iopeb_reset_filter.sv ====
// iopeb_reset_filter: filters the external reset and stretches the internal one.
// assumes reset_in_n is synchronous to mclk; each mclk counts as one input period.
module iopeb_reset_filter (
   input  wire logic mclk,
   input  wire logic rstn,
   input  wire logic reset_in_n,
   output logic      int_reset
);
   logic [4:0] low_cnt_reg;
   logic [4:0] hold_cnt_reg;
   logic       int_reset_reg;
   wire        latch_now = (low_cnt_reg == 5'(iopeb_pkg::LATCH_PERIOD - 1)) && !reset_in_n;
   wire        hold_done = (hold_cnt_reg == 5'(iopeb_pkg::HOLD_PERIODS - 1));

   // ==========================================
   // low pulse counter: short glitches clear before reaching the latch point
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         low_cnt_reg <= 5'h00;
      end else if (reset_in_n) begin
         low_cnt_reg <= 5'h00;
      end else if (low_cnt_reg < 5'(iopeb_pkg::LATCH_PERIOD)) begin
         low_cnt_reg <= low_cnt_reg + 5'h01;
      end
   end

   // ==========================================
   // internal reset: held 18 periods or while the pin is low, whichever longer
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         int_reset_reg <= 1'b1;
         hold_cnt_reg  <= 5'h00;
      end else if (latch_now) begin
         int_reset_reg <= 1'b1;
         hold_cnt_reg  <= 5'h00;
      end else if (int_reset_reg) begin
         if (!hold_done) begin
            hold_cnt_reg <= hold_cnt_reg + 5'h01;
         end else if (reset_in_n) begin
            int_reset_reg <= 1'b0;
         end
      end
   end

   assign int_reset = int_reset_reg;
endmodule

// ==== iopeb_top.sv ====
// iopeb_top: four 8-bit ports, their port-3 alternate functions and the
// multiplexed external memory bus. assumes a core that issues fetch, read and
// write requests and register accesses; all inputs synchronous to mclk.
// Summary of operation
// - data strobe pulses once per transfer
// - address strobe pulses at each cycle start
// - program control floats strobes, r/w, ports 0,1
// - read/write low only during writes
// - reset lows under four periods ignored
// - internal reset latched fifth clock, held 18+
// - in reset data strobe low, address strobe toggles
// - fetching restarts at address 000c after reset
// - port 0 nibbles each address or i/o
// - port 0 handshake on lines 2 and 5
// - reset: port 0 address, extended timing
// - port 1 multiplexes low address and data
// - bus request out, acknowledge in on port 3
// - port 2 per-bit direction, global open-drain
// - port 2 handshake on lines 1 and 6
// - port 3: four fixed inputs, four outputs
// - port 3 inputs give irqs and timer input
// - data space select low for data loads
// - 16-bit address, vectors in lowest 12 bytes
module iopeb_top (
   input  wire logic        mclk,
   input  wire logic        rstn,
   input  wire logic        reset_in_n,
   // core memory request
   input  wire logic        mem_req,
   input  wire logic        mem_write,
   input  wire logic        mem_data_space,
   input  wire logic [15:0] mem_addr,
   input  wire logic [7:0]  mem_wdata,
   output logic             mem_ready,
   output logic [7:0]       mem_rdata,
   output logic [15:0]      fetch_addr,
   output logic             core_reset,
   // core register access
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   output logic [7:0]       reg_rdata,
   // core alternate functions
   input  wire logic        timer_output,
   output logic [3:0]       ext_irq_lines,
   output logic             timer_input,
   // external bus
   output logic             address_strobe_n,
   output logic             address_strobe_oe,
   output logic             data_strobe_n,
   output logic             data_strobe_oe,
   output logic             read_write,
   output logic             read_write_oe,
   // ports
   input  wire logic [7:0]  port0_in,
   output logic [7:0]       port0_out,
   output logic [7:0]       port0_oe,
   input  wire logic [7:0]  port1_in,
   output logic [7:0]       port1_out,
   output logic [7:0]       port1_oe,
   input  wire logic [7:0]  port2_in,
   output logic [7:0]       port2_out,
   output logic [7:0]       port2_oe,
   input  wire logic [3:0]  port3_in,
   output logic [3:0]       port3_out
);
   // ==========================================
   // reset filter
   logic int_reset;
   iopeb_reset_filter u_filter (
      .mclk       (mclk),
      .rstn       (rstn),
      .reset_in_n (reset_in_n),
      .int_reset  (int_reset)
   );
   assign core_reset = int_reset;
   assign fetch_addr = iopeb_pkg::START_ADDR;

   // ==========================================
   // registers
   logic [7:0] p0_data_reg, p2_data_reg, p3_out_reg;
   logic [7:0] p2m_reg, p3m_reg, port_zero_one_config_reg;
   wire wr_p0   = reg_wr && (reg_addr == iopeb_pkg::OFF_PORT_ZERO_DATA);
   wire wr_p2   = reg_wr && (reg_addr == iopeb_pkg::OFF_PORT_TWO_DATA);
   wire wr_p3   = reg_wr && (reg_addr == iopeb_pkg::OFF_PORT_THREE_DATA);
   wire wr_p2m  = reg_wr && (reg_addr == iopeb_pkg::OFF_PORT_TWO_CONFIG);
   wire wr_p3m  = reg_wr && (reg_addr == iopeb_pkg::OFF_PORT_THREE_CONFIG);
   wire wr_port_zero_one_config = reg_wr && (reg_addr == iopeb_pkg::OFF_PORT_ZERO_ONE_CONFIG);

   wire lo_addr   = port_zero_one_config_reg[iopeb_pkg::P01_LO_ADDR_BIT];
   wire hi_addr   = port_zero_one_config_reg[iopeb_pkg::P01_HI_ADDR_BIT];
   wire lo_out    = port_zero_one_config_reg[iopeb_pkg::P01_LO_OUT_BIT];
   wire hi_out    = port_zero_one_config_reg[iopeb_pkg::P01_HI_OUT_BIT];
   wire float_req = port_zero_one_config_reg[iopeb_pkg::P01_FLOAT_BIT];
   wire ext_time  = port_zero_one_config_reg[iopeb_pkg::P01_EXT_TIME_BIT];
   wire p2_od     = p3m_reg[iopeb_pkg::P3M_P2_OPEN_DRAIN_BIT];
   wire hs2_en    = p3m_reg[iopeb_pkg::P3M_HS2_EN_BIT];
   wire hs0_en    = p3m_reg[iopeb_pkg::P3M_HS0_EN_BIT] && (lo_out == hi_out)
                    && !lo_addr && !hi_addr;
   wire dm_en     = p3m_reg[iopeb_pkg::P3M_DM_EN_BIT];

   // handshake: output-direction port drives data_avail on the output line
   // and reads ready on the input line; input-direction swaps roles
   wire bus_ack   = port3_in[3];
   logic hs0_flag_reg, hs2_flag_reg;
   wire hs0_in_line = port3_in[2];
   wire hs2_in_line = port3_in[1];
   wire p2_top_out  = !p2m_reg[7];
   wire hs0_strobe  = hs0_en && ((hi_out && wr_p0) || (!hi_out && !hs0_in_line && !hs0_flag_reg));
   wire hs2_strobe  = hs2_en && ((p2_top_out && wr_p2) || (!p2_top_out && !hs2_in_line
                     && !hs2_flag_reg));

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         p2m_reg  <= iopeb_pkg::P2M_RESET;
         p3m_reg  <= iopeb_pkg::P3M_RESET;
         port_zero_one_config_reg <= iopeb_pkg::P01_RESET;
      end else if (int_reset) begin
         p2m_reg  <= iopeb_pkg::P2M_RESET;
         p3m_reg  <= iopeb_pkg::P3M_RESET;
         port_zero_one_config_reg <= iopeb_pkg::P01_RESET;
      end else begin
         if (wr_p2m)  p2m_reg  <= reg_wdata;
         if (wr_p3m)  p3m_reg  <= reg_wdata;
         if (wr_port_zero_one_config) port_zero_one_config_reg <= reg_wdata;
      end
   end

   // input-mode handshake latches pin data on the data-available edge
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         p0_data_reg <= iopeb_pkg::DATA_RESET;
         p2_data_reg <= iopeb_pkg::DATA_RESET;
         p3_out_reg  <= iopeb_pkg::DATA_RESET;
      end else begin
         if (wr_p0) p0_data_reg <= reg_wdata;
         else if (hs0_en && !hi_out && hs0_strobe) p0_data_reg <= port0_in;
         if (wr_p2) p2_data_reg <= reg_wdata;
         else if (hs2_en && !p2_top_out && hs2_strobe) p2_data_reg <= port2_in;
         if (wr_p3) p3_out_reg <= reg_wdata;
      end
   end

   // flag set = transfer pending; cleared by the partner's answer or a data register read
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         hs0_flag_reg <= 1'b0;
         hs2_flag_reg <= 1'b0;
      end else begin
         if (hs0_strobe) hs0_flag_reg <= 1'b1;
         else if ((hi_out && !hs0_in_line) || (!hi_out && reg_rd
                  && reg_addr == iopeb_pkg::OFF_PORT_ZERO_DATA)) hs0_flag_reg <= 1'b0;
         if (hs2_strobe) hs2_flag_reg <= 1'b1;
         else if ((p2_top_out && !hs2_in_line) || (!p2_top_out && reg_rd
                  && reg_addr == iopeb_pkg::OFF_PORT_TWO_DATA)) hs2_flag_reg <= 1'b0;
      end
   end

   // ==========================================
   // external bus sequencer
   iopeb_pkg::iopeb_state_t state_reg, state_next;
   logic [1:0]  phase_cnt_reg;
   logic [15:0] addr_reg;
   logic [7:0]  wdata_reg, rdata_reg;
   logic        write_reg, dspace_reg, as_tog_reg, float_reg;
   wire  [1:0]  phase_len = ext_time ? 2'(iopeb_pkg::EXT_PHASE) : 2'(iopeb_pkg::NORM_PHASE);
   wire         phase_done = (phase_cnt_reg == phase_len - 2'h1);
   wire         granted = float_reg && bus_ack;
   wire         start = mem_req && !granted && !int_reset;

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         iopeb_pkg::IOPEB_IDLE: if (start) state_next = iopeb_pkg::IOPEB_ADDR;
         iopeb_pkg::IOPEB_ADDR: if (phase_done) state_next = iopeb_pkg::IOPEB_GAP;
         iopeb_pkg::IOPEB_GAP:  state_next = iopeb_pkg::IOPEB_DATA;
         iopeb_pkg::IOPEB_DATA: if (phase_done) state_next = iopeb_pkg::IOPEB_END;
         iopeb_pkg::IOPEB_END:  state_next = iopeb_pkg::IOPEB_IDLE;
         default:               state_next = iopeb_pkg::IOPEB_IDLE;
      endcase
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         state_reg     <= iopeb_pkg::IOPEB_IDLE;
         phase_cnt_reg <= 2'h0;
      end else if (int_reset) begin
         state_reg     <= iopeb_pkg::IOPEB_IDLE;
         phase_cnt_reg <= 2'h0;
      end else begin
         state_reg     <= state_next;
         phase_cnt_reg <= (state_next != state_reg) ? 2'h0 : phase_cnt_reg + 2'h1;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         addr_reg   <= 16'h0000;
         wdata_reg  <= 8'h00;
         rdata_reg  <= 8'h00;
         write_reg  <= 1'b0;
         dspace_reg <= 1'b0;
         as_tog_reg <= 1'b1;
         float_reg  <= 1'b0;
      end else begin
         as_tog_reg <= int_reset ? !as_tog_reg : 1'b1;
         // float only between cycles so no transfer is cut short
         if (int_reset) float_reg <= 1'b0;
         else if (state_reg == iopeb_pkg::IOPEB_IDLE && !start) float_reg <= float_req;
         if (state_reg == iopeb_pkg::IOPEB_IDLE && start) begin
            addr_reg   <= mem_addr;
            wdata_reg  <= mem_wdata;
            write_reg  <= mem_write;
            dspace_reg <= mem_data_space;
         end
         if (state_reg == iopeb_pkg::IOPEB_DATA && phase_done && !write_reg)
            rdata_reg <= port1_in;
      end
   end

   wire in_addr  = (state_reg == iopeb_pkg::IOPEB_ADDR);
   wire in_data  = (state_reg == iopeb_pkg::IOPEB_DATA);
   wire in_cycle = (state_reg != iopeb_pkg::IOPEB_IDLE);
   // reset takes the pins back at once so the strobes stay visible as a group
   wire drive    = !float_reg || int_reset;
   assign mem_ready = (state_reg == iopeb_pkg::IOPEB_END);
   assign mem_rdata = rdata_reg;

   // address valid on port 1, and on port 0 nibbles in address mode, through each strobe low outside reset
   assign address_strobe_n  = int_reset ? as_tog_reg : !in_addr;
   assign data_strobe_n     = int_reset ? 1'b0 : !in_data;
   assign read_write        = !(in_data && write_reg);
   assign address_strobe_oe = drive;
   assign data_strobe_oe    = drive;
   assign read_write_oe     = drive;

   // ==========================================
   // port drivers
   wire p1_addr_phase = in_addr || (state_reg == iopeb_pkg::IOPEB_GAP);
   assign port1_out = p1_addr_phase ? addr_reg[7:0] : wdata_reg;
   assign port1_oe  = {8{drive && (p1_addr_phase || (in_cycle && write_reg
                        && state_reg != iopeb_pkg::IOPEB_ADDR))}};

   assign port0_out[3:0] = lo_addr ? addr_reg[11:8]  : p0_data_reg[3:0];
   assign port0_out[7:4] = hi_addr ? addr_reg[15:12] : p0_data_reg[7:4];
   assign port0_oe[3:0]  = {4{drive && (lo_addr || lo_out)}};
   assign port0_oe[7:4]  = {4{drive && (hi_addr || hi_out)}};

   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_p2
         wire out_bit = !p2m_reg[gi];
         // open-drain: drive only the low level
         assign port2_out[gi] = p2_data_reg[gi];
         assign port2_oe[gi]  = out_bit && (!p2_od || !p2_data_reg[gi]);
      end
   endgenerate

   // ==========================================
   // port 3: fixed direction, alternate functions
   assign ext_irq_lines = {port3_in[0], port3_in[1], port3_in[3], port3_in[2]};
   assign timer_input   = port3_in[1];
   assign port3_out[0] = (dm_en && in_cycle) ? !dspace_reg : p3_out_reg[4]
                         & !float_reg;
   assign port3_out[1] = hs0_en ? (hi_out ? !hs0_flag_reg : !hs0_flag_reg)
                         : p3_out_reg[5];
   assign port3_out[2] = hs2_en ? !hs2_flag_reg : timer_output && p3_out_reg[6];
   assign port3_out[3] = p3_out_reg[7];

   // reads: fixed input bits come from pins, config registers are write-only
   always_comb begin
      unique case (reg_addr)
         iopeb_pkg::OFF_PORT_ZERO_DATA:  reg_rdata = p0_data_reg;
         iopeb_pkg::OFF_PORT_TWO_DATA:   reg_rdata = p2_data_reg;
         iopeb_pkg::OFF_PORT_THREE_DATA: reg_rdata = {p3_out_reg[7:4], port3_in};
         default:                        reg_rdata = 8'hff;
      endcase
   end
endmodule

// ==== iopeb_asserts.sv ====
// iopeb_asserts: port-level checks of reset, external bus and port 3 paths.
// assumes it is bound onto iopeb_top; one mclk domain, rstn async active low.
module iopeb_checker (
   input wire logic        mclk,
   input wire logic        rstn,
   input wire logic        reset_in_n,
   input wire logic        core_reset,
   input wire logic        mem_ready,
   input wire logic [15:0] mem_addr,
   input wire logic [7:0]  mem_wdata,
   input wire logic        address_strobe_n,
   input wire logic        address_strobe_oe,
   input wire logic        data_strobe_n,
   input wire logic        data_strobe_oe,
   input wire logic        read_write,
   input wire logic        read_write_oe,
   input wire logic [7:0]  port1_out,
   input wire logic [7:0]  port1_oe,
   input wire logic [3:0]  port3_in,
   input wire logic [3:0]  ext_irq_lines,
   input wire logic        timer_input
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);
   // ==========================================
   // bus steps
   sequence s_ds_close;
      ##[1:2] (data_strobe_n && mem_ready);
   endsequence
   // eight cycles covers the longest cycle already under way at grant time
   sequence s_granted;
      (port3_in[3] && !address_strobe_oe)[*8];
   endsequence
   // ==========================================
   // assertions
   chk_reset_ds_low: assert property (core_reset |-> !data_strobe_n)
      else $error("data strobe high during internal reset");
   chk_reset_as_toggle: assert property (core_reset && $past(core_reset) && $past(rstn) |-> address_strobe_n != $past(address_strobe_n))
      else $error("address strobe stopped toggling in reset");
   chk_reset_hold: assert property ($fell(core_reset) |-> $past(core_reset, 18) && $past(reset_in_n))
      else $error("internal reset released early");
   chk_glitch_ignored: assert property ($rose(core_reset) |-> !$past(reset_in_n, 2) && !$past(reset_in_n, 3) && !$past(reset_in_n, 4) && !$past(reset_in_n, 5))
      else $error("reset taken from a short low pulse");
   chk_float_group: assert property (!address_strobe_oe |-> !data_strobe_oe && !read_write_oe && port1_oe == 8'h00)
      else $error("bus pins not floated together");
   chk_rw_write_only: assert property (!read_write && read_write_oe |-> !data_strobe_n)
      else $error("read_write low outside a write strobe");
   chk_addr_port1: assert property (!address_strobe_n && address_strobe_oe && !core_reset |-> port1_out == mem_addr[7:0] && port1_oe == 8'hff)
      else $error("port 1 not showing low address");
   chk_write_data: assert property (!data_strobe_n && !read_write && data_strobe_oe |-> port1_out == mem_wdata && port1_oe == 8'hff)
      else $error("port 1 not showing write data");
   chk_ds_close: assert property ($fell(data_strobe_n) && !core_reset |-> s_ds_close)
      else $error("data strobe not closed by ready");
   chk_irq_map: assert property (ext_irq_lines == {port3_in[0], port3_in[1], port3_in[3], port3_in[2]} && timer_input == port3_in[1])
      else $error("port 3 interrupt or timer mapping wrong");
   chk_granted_idle: assert property (s_granted |-> address_strobe_n && !mem_ready)
      else $error("bus cycle while granted away");
endmodule

bind iopeb_top iopeb_checker u_chk (.mclk(mclk), .rstn(rstn), .reset_in_n(reset_in_n),
   .core_reset(core_reset), .mem_ready(mem_ready), .mem_addr(mem_addr),
   .mem_wdata(mem_wdata), .address_strobe_n(address_strobe_n),
   .address_strobe_oe(address_strobe_oe), .data_strobe_n(data_strobe_n),
   .data_strobe_oe(data_strobe_oe), .read_write(read_write), .read_write_oe(read_write_oe),
   .port1_out(port1_out), .port1_oe(port1_oe), .port3_in(port3_in),
   .ext_irq_lines(ext_irq_lines), .timer_input(timer_input));

// ==== iopeb_mem_model.sv ====
// iopeb_mem_model: external program/data memory on the multiplexed bus.
// assumes port 0 carries the whole high address byte, port 1 low byte and data.
module iopeb_mem_model (
   input  wire logic       mclk,
   input  wire logic       address_strobe_n,
   input  wire logic       data_strobe_n,
   input  wire logic       data_strobe_oe,
   input  wire logic       read_write,
   input  wire logic [7:0] port0_out,
   input  wire logic [7:0] port1_out,
   output logic      [7:0] port1_in
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0]  mem [0:65535];
   logic [15:0] addr_q;
   logic [7:0]  hold_q = 8'h5a;
   wire         rd_on = !data_strobe_n && read_write && data_strobe_oe;
   initial for (int i = 0; i < 65536; i++) mem[i] = i[7:0] ^ i[15:8] ^ 8'h3c;
   // sampled on the clock, not the strobe edge, to avoid racing port 1
   always @(posedge mclk) if (!address_strobe_n) addr_q <= {port0_out, port1_out};
   // released lines show the inverse of the last byte so stale data never matches
   assign port1_in = rd_on ? mem[addr_q] : ~hold_q;
   always @(posedge mclk) begin
      if (rd_on) hold_q <= mem[addr_q];
      if (!data_strobe_n && !read_write && data_strobe_oe) mem[addr_q] <= port1_out;
   end
endmodule

// ==== iopeb_tb.sv ====
// testbench: drives core, register and port inputs of iopeb_top with a memory
// model on the bus; assumes the checker is bound in separately.
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int LAT_N = 4;  // falling edges from raising mem_req to mem_ready
   localparam int LAT_E = 6;
   logic        mclk = 0, rstn = 0, reset_in_n = 1, mem_req = 0, mem_write = 0;
   logic        mem_data_space = 0, mem_ready, core_reset, reg_wr = 0, reg_rd = 0;
   logic        timer_output = 0, timer_input, address_strobe_n, address_strobe_oe;
   logic        data_strobe_n, data_strobe_oe, read_write, read_write_oe;
   logic [15:0] mem_addr = 0, fetch_addr;
   logic [7:0]  mem_wdata = 0, mem_rdata, reg_addr = 0, reg_wdata = 0, reg_rdata, d;
   logic [7:0]  port0_in = 0, port0_out, port0_oe, port1_in, port1_out, port1_oe;
   logic [7:0]  port2_in = 8'h3c, port2_out, port2_oe;
   logic [3:0]  port3_in = 0, port3_out, ext_irq_lines;
   int          error_cnt = 0, total_checks = 0, n;
   always #10 mclk = ~mclk;
   iopeb_top DUT (.*);
   iopeb_mem_model u_mem (.*);
   // ==========================================
   // helpers
   function automatic logic [7:0] pat(input logic [15:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h3c;
   endfunction
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic reg_write(input logic [7:0] a, input logic [7:0] v);
      @(negedge mclk);
      reg_addr = a;
      reg_wdata = v;
      reg_wr = 1;
      @(negedge mclk);
      reg_wr = 0;
   endtask
   task automatic reg_read(input logic [7:0] a, output logic [7:0] v);
      @(negedge mclk);
      reg_addr = a;
      reg_rd = 1;
      @(posedge mclk);
      v = reg_rdata;
      @(negedge mclk);
      reg_rd = 0;
   endtask
   // request held until mem_ready, as the core would
   task automatic mem_op(input logic wr, input logic [15:0] a, input logic [7:0] wd,
                         output int lat, output logic [7:0] rd);
      @(negedge mclk);
      mem_write = wr;
      mem_addr = a;
      mem_wdata = wd;
      mem_req = 1;
      lat = 0;
      do begin
         @(negedge mclk);
         lat++;
      end while (mem_ready !== 1'b1 && lat < 60);
      if (lat >= 60) begin
         error_cnt++;
         end_sim();
      end
      rd = mem_rdata;
      mem_req = 0;
   endtask
   task automatic wait_rst(output int c);
      c = 0;
      while (core_reset !== 1'b0) begin
         @(negedge mclk);
         c++;
         if (c > 200) begin
            error_cnt++;
            end_sim();
         end
      end
   endtask
   // ==========================================
   // sequence
   initial begin
      repeat (3) @(negedge mclk);
      rstn = 1;
      wait_rst(n);
      check(16'(n >= 18), 16'h1);
      check(fetch_addr, 16'h000c);
      reg_read(iopeb_pkg::OFF_PORT_ZERO_ONE_CONFIG, d);
      check(d, 8'hff);
      reg_read(8'h10, d);
      check(d, 8'hff);
      mem_op(0, 16'h1234, 8'h00, n, d);
      check(16'(n), 16'(LAT_E));
      check(d, pat(16'h1234));
      reg_write(iopeb_pkg::OFF_PORT_ZERO_ONE_CONFIG, 8'h03);
      mem_op(1, 16'hbe07, 8'h96, n, d);
      check(16'(n), 16'(LAT_N));
      mem_op(0, 16'hbe07, 8'h00, n, d);
      check(d, 8'h96);
      mem_op(0, 16'h00ff, 8'h00, n, d);
      check(d, pat(16'h00ff));
      // high nibble as output: address then mixes in its data bits
      reg_write(iopeb_pkg::OFF_PORT_ZERO_ONE_CONFIG, 8'h09);
      reg_write(iopeb_pkg::OFF_PORT_ZERO_DATA, 8'ha5);
      check({port0_oe[7:4], port0_out[7:4]}, 8'hfa);
      mem_op(0, 16'h0c40, 8'h00, n, d);
      check(d, pat(16'hac40));
      reg_write(iopeb_pkg::OFF_PORT_TWO_CONFIG, 8'h0f);
      reg_write(iopeb_pkg::OFF_PORT_TWO_DATA, 8'h5c);
      check({port2_oe, port2_out & 8'hf0}, 16'hf050);
      reg_read(iopeb_pkg::OFF_PORT_TWO_DATA, d);
      check(d[3:0], 4'hc);
      reg_write(iopeb_pkg::OFF_PORT_THREE_CONFIG, 8'h01);
      check(port2_oe, 8'ha0);
      for (int i = 0; i < 16; i++) begin
         port3_in = i[3:0];
         reg_read(iopeb_pkg::OFF_PORT_THREE_DATA, d);
         check(d[3:0], i[3:0]);
      end
      port3_in = 4'h0;
      reg_write(iopeb_pkg::OFF_PORT_THREE_DATA, 8'h90);
      check(port3_out, 4'h9);
      reg_write(iopeb_pkg::OFF_PORT_ZERO_ONE_CONFIG, 8'h13);
      @(negedge mclk);
      check(address_strobe_oe, 1'b0);
      port3_in[3] = 1'b1;
      fork
         begin
            repeat (12) @(negedge mclk);
            port3_in[3] = 1'b0;
         end
         mem_op(0, 16'h0345, 8'h00, n, d);
      join
      check(16'(n > 11), 16'h1);
      reset_in_n = 0;
      repeat (4) @(negedge mclk);
      reset_in_n = 1;
      repeat (6) @(negedge mclk);
      check(core_reset, 1'b0);
      reset_in_n = 0;
      repeat (8) @(negedge mclk);
      check(core_reset, 1'b1);
      reset_in_n = 1;
      wait_rst(n);
      check(16'(n >= 10), 16'h1);
      mem_op(0, 16'h2001, 8'h00, n, d);
      check(16'(n), 16'(LAT_E));
      check(d, pat(16'h2001));
      end_sim();
   end
endmodule
